// File: logic/gcs_pkg.sv
package gcs_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam longint SECOND_NS = 1000000000;
	localparam int SEC_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
	localparam int INACT_MINUTES = 15;
	localparam int INACT_SECONDS = INACT_MINUTES * 60;
	localparam int RST_DELAY_S = 10;
	localparam logic [9:0] INACT_LAST = 10'(INACT_SECONDS - 1);
	localparam logic [3:0] RST_LAST = 4'(RST_DELAY_S - 1);
	localparam logic [16:0] SECS_PER_HOUR = 17'h00e10;
	localparam logic [16:0] SECS_PER_MIN = 17'h0003c;

	// register byte addresses
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_ARG = 8'h04;
	localparam logic [7:0] ADDR_ARG2 = 8'h08;
	localparam logic [7:0] ADDR_RESP = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_TIME = 8'h14;
	localparam logic [7:0] ADDR_SYNC = 8'h18;
	localparam logic [7:0] ADDR_SNAP_TIME = 8'h1c;
	localparam logic [7:0] ADDR_SNAP_REMAIN = 8'h20;
	localparam logic [7:0] ADDR_FIRST_ON = 8'h24;
	localparam logic [7:0] ADDR_VERSION = 8'h28;
	localparam logic [7:0] ADDR_POS_LAT = 8'h2c;
	localparam logic [7:0] ADDR_POS_LON = 8'h30;

	// command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_HAS_ARG_BIT = 4;
	localparam int CMD_ARG_ON_BIT = 5;
	// hh:mm:ss word fields
	localparam int HOUR_LSB = 12;
	localparam int MIN_LSB = 6;
	localparam int SEC_LSB = 0;

	// opcodes
	localparam logic [3:0] OP_SET_MODE = 4'h1;
	localparam logic [3:0] OP_TEST_MODE = 4'h2;
	localparam logic [3:0] OP_SYNC = 4'h3;
	localparam logic [3:0] OP_TIME = 4'h4;
	localparam logic [3:0] OP_STATUS = 4'h5;
	localparam logic [3:0] OP_VERSION = 4'h6;
	localparam logic [3:0] OP_RCV_RESET = 4'h7;
	localparam logic [3:0] OP_POSITION = 4'h8;

	// response results
	localparam logic [1:0] RES_OK = 2'h0;
	localparam logic [1:0] RES_REFUSED = 2'h1;
	localparam logic [1:0] RES_BAD_OP = 2'h2;
	localparam logic [1:0] RES_RESET_DONE = 2'h3;

	// limits and reset values
	localparam logic [4:0] MAX_HOUR = 5'h17;
	localparam logic [5:0] MAX_MIN = 6'h3b;
	localparam logic [5:0] MAX_SEC = 6'h3c;
	localparam logic [4:0] SYNC_DEF_H = 5'h02;
	localparam logic [5:0] SYNC_DEF_M = 6'h00;
	localparam logic [5:0] SYNC_DEF_S = 6'h00;
	// arbitrary value, names no real firmware level
	localparam logic [31:0] VERSION_ID = 32'h00010000;

	typedef enum logic [1:0] {
		MODE_READ = 2'b00,
		MODE_SET  = 2'b01,
		MODE_TEST = 2'b10
	} gcs_mode_t;
endpackage

// File: logic/gcs_tod_counter.sv
`timescale 1ns/10ps
module gcs_tod_counter (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       secTick,
	input  wire logic       loadEn,
	input  wire logic [4:0] loadHours,
	input  wire logic [5:0] loadMinutes,
	input  wire logic [5:0] loadSeconds,
	output logic      [4:0] hours,
	output logic      [5:0] minutes,
	output logic      [5:0] seconds
);
	import gcs_pkg::*;

	logic [4:0] next_hours;
	logic [5:0] next_minutes;
	logic [5:0] next_seconds;

	always_comb begin
		next_hours = hours;
		next_minutes = minutes;
		next_seconds = seconds;
		if (loadEn) begin
			next_hours = loadHours;
			next_minutes = loadMinutes;
			next_seconds = loadSeconds;
		end else if (secTick) begin
			// a loaded leap second 60 rolls over like 59
			if (seconds >= MAX_MIN) begin
				next_seconds = 6'h00;
				if (minutes == MAX_MIN) begin
					next_minutes = 6'h00;
					next_hours = (hours == MAX_HOUR) ? 5'h00 : hours + 5'h01;
				end else begin
					next_minutes = minutes + 6'h01;
				end
			end else begin
				next_seconds = seconds + 6'h01;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hours <= 5'h00;
			minutes <= 6'h00;
			seconds <= 6'h00;
		end else begin
			hours <= next_hours;
			minutes <= next_minutes;
			seconds <= next_seconds;
		end
	end
endmodule // gcs_tod_counter

// File: logic/gcs_setup_cmd.sv
`timescale 1ns/10ps
module gcs_setup_cmd
	import gcs_pkg::*;
#(
	parameter int SEC_CYCLES_P = SEC_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        rcvTracking,
	input  wire logic        rcvTimeValid,
	input  wire logic [4:0]  rcvHours,
	input  wire logic [5:0]  rcvMinutes,
	input  wire logic [5:0]  rcvSeconds,
	output logic             majorAlarm,
	output logic             minorAlarm,
	output logic             syncOutEnable,
	output logic             rcvResetPulse
);
	import gcs_pkg::*;

	logic trackMeta;
	logic trackSync;
	gcs_mode_t mode;
	gcs_mode_t next_mode;
	logic [9:0] inactCnt;
	logic [9:0] next_inactCnt;
	logic [31:0] argReg;
	logic [31:0] next_argReg;
	logic [31:0] arg2Reg;
	logic [31:0] next_arg2Reg;
	logic [3:0] respOp;
	logic [3:0] next_respOp;
	logic [1:0] respResult;
	logic [1:0] next_respResult;
	logic respStateOn;
	logic next_respStateOn;
	logic [7:0] respSeq;
	logic [7:0] next_respSeq;
	logic [4:0] syncH;
	logic [4:0] next_syncH;
	logic [5:0] syncM;
	logic [5:0] next_syncM;
	logic [5:0] syncS;
	logic [5:0] next_syncS;
	logic [16:0] snapTime;
	logic [16:0] next_snapTime;
	logic [16:0] snapRemain;
	logic [16:0] next_snapRemain;
	logic [16:0] firstOn;
	logic [16:0] next_firstOn;
	logic firstOnValid;
	logic next_firstOnValid;
	logic [31:0] posLat;
	logic [31:0] next_posLat;
	logic [31:0] posLon;
	logic [31:0] next_posLon;
	logic next_rcvResetPulse;
	logic rstDoneSeen;
	logic next_rstDoneSeen;
	logic [31:0] next_rdata;

	logic [27:0] secCnt;
	logic [27:0] next_secCnt;
	logic secTick;
	logic next_secTick;
	logic [16:0] syncCnt;
	logic [16:0] next_syncCnt;
	logic syncAlarm;
	logic next_syncAlarm;
	logic rstBusy;
	logic next_rstBusy;
	logic [3:0] rstCnt;
	logic [3:0] next_rstCnt;
	logic rstDone;
	logic next_rstDone;
	logic next_majorAlarm;
	logic next_minorAlarm;
	logic next_syncOutEnable;

	logic cmdWr;
	logic [3:0] op;
	logic hasArg;
	logic argOn;
	logic [4:0] argH;
	logic [5:0] argM;
	logic [5:0] argS;
	logic [16:0] syncPeriodS;
	logic [16:0] syncRemain;
	logic todLoad;
	logic [4:0] todLoadH;
	logic [5:0] todLoadM;
	logic [5:0] todLoadS;
	logic [4:0] hours;
	logic [5:0] minutes;
	logic [5:0] seconds;
	logic [16:0] todWord;

	assign cmdWr = wr && (addr == ADDR_CMD);
	assign op = wdata[CMD_OP_LSB +: 4];
	assign hasArg = wdata[CMD_HAS_ARG_BIT];
	assign argOn = wdata[CMD_ARG_ON_BIT];
	assign argH = argReg[HOUR_LSB +: 5];
	assign argM = argReg[MIN_LSB +: 6];
	assign argS = argReg[SEC_LSB +: 6];
	assign todWord = {hours, minutes, seconds};
	assign syncPeriodS = 17'(syncH) * SECS_PER_HOUR + 17'(syncM) * SECS_PER_MIN + 17'(syncS);
	assign syncRemain = syncPeriodS - syncCnt;

	// receiver time wins over a manual entry in the same cycle
	always_comb begin
		todLoad = 1'b0;
		todLoadH = argH;
		todLoadM = argM;
		todLoadS = argS;
		if (rcvTimeValid && trackSync) begin
			todLoad = 1'b1;
			todLoadH = rcvHours;
			todLoadM = rcvMinutes;
			todLoadS = rcvSeconds;
		end else if (cmdWr && op == OP_TIME && hasArg && mode == MODE_SET
				&& argH <= MAX_HOUR && argM <= MAX_MIN && argS <= MAX_SEC) begin
			todLoad = 1'b1;
		end
	end

	gcs_tod_counter u_tod (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.secTick     (secTick),
		.loadEn      (todLoad),
		.loadHours   (todLoadH),
		.loadMinutes (todLoadM),
		.loadSeconds (todLoadS),
		.hours       (hours),
		.minutes     (minutes),
		.seconds     (seconds)
	);

	// command, mode and register group
	always_comb begin
		next_mode = mode;
		next_inactCnt = inactCnt;
		next_argReg = argReg;
		next_arg2Reg = arg2Reg;
		next_respOp = respOp;
		next_respResult = respResult;
		next_respStateOn = respStateOn;
		next_respSeq = respSeq;
		next_syncH = syncH;
		next_syncM = syncM;
		next_syncS = syncS;
		next_snapTime = snapTime;
		next_snapRemain = snapRemain;
		next_firstOn = firstOn;
		next_firstOnValid = firstOnValid;
		next_posLat = posLat;
		next_posLon = posLon;
		next_rcvResetPulse = 1'b0;
		next_rstDoneSeen = rstDoneSeen;
		if (wr && addr == ADDR_ARG) begin
			next_argReg = wdata;
		end
		if (wr && addr == ADDR_ARG2) begin
			next_arg2Reg = wdata;
		end
		if (rcvTimeValid && trackSync && !firstOnValid) begin
			next_firstOn = {rcvHours, rcvMinutes, rcvSeconds};
			next_firstOnValid = 1'b1;
		end
		if (cmdWr) begin
			next_inactCnt = 10'h000;
			next_respSeq = respSeq + 8'h01;
			next_respOp = op;
			next_respResult = RES_OK;
			next_respStateOn = 1'b0;
			case (op)
				OP_SET_MODE: begin
					if (hasArg && argOn) begin
						next_mode = MODE_SET;
					end else if (hasArg && mode == MODE_SET) begin
						next_mode = MODE_READ;
					end
					next_respStateOn = hasArg ? argOn : (mode == MODE_SET);
				end
				OP_TEST_MODE: begin
					if (hasArg && argOn) begin
						next_mode = MODE_TEST;
					end else if (hasArg && mode == MODE_TEST) begin
						next_mode = MODE_READ;
					end
					next_respStateOn = hasArg ? argOn : (mode == MODE_TEST);
					next_snapTime = todWord;
				end
				OP_SYNC: begin
					if (hasArg) begin
						if (mode != MODE_SET || argM > MAX_MIN || argS > MAX_MIN) begin
							next_respResult = RES_REFUSED;
						end else begin
							next_syncH = argH;
							next_syncM = argM;
							next_syncS = argS;
						end
					end
				end
				OP_TIME: begin
					if (hasArg && !todLoad) begin
						next_respResult = RES_REFUSED;
					end
				end
				OP_STATUS: begin
					next_snapTime = todWord;
					next_snapRemain = syncRemain;
				end
				OP_VERSION: begin
					next_respStateOn = firstOnValid;
				end
				OP_RCV_RESET: begin
					if (mode != MODE_TEST || rstBusy) begin
						next_respResult = RES_REFUSED;
					end else begin
						next_rcvResetPulse = 1'b1;
						next_rstDoneSeen = 1'b0;
					end
				end
				OP_POSITION: begin
					if (mode != MODE_SET) begin
						next_respResult = RES_REFUSED;
					end else begin
						next_posLat = argReg;
						next_posLon = arg2Reg;
					end
				end
				default: begin
					next_respResult = RES_BAD_OP;
				end
			endcase
		end else if (secTick && mode != MODE_READ) begin
			if (inactCnt == INACT_LAST) begin
				next_mode = MODE_READ;
				next_inactCnt = 10'h000;
			end else begin
				next_inactCnt = inactCnt + 10'h001;
			end
		end
		// a done event colliding with a command still sets the sticky bit
		if (rstDone) begin
			next_rstDoneSeen = 1'b1;
			if (!cmdWr) begin
				next_respOp = OP_RCV_RESET;
				next_respResult = RES_RESET_DONE;
				next_respSeq = respSeq + 8'h01;
			end
		end
		next_rdata = 32'h00000000;
		if (rd) begin
			case (addr)
				ADDR_ARG: next_rdata = argReg;
				ADDR_ARG2: next_rdata = arg2Reg;
				ADDR_RESP: next_rdata = {16'h0000, respSeq, 1'b0, respStateOn, respResult, respOp};
				ADDR_STATUS: next_rdata = {23'h000000, rstDoneSeen, firstOnValid, rstBusy,
					minorAlarm, majorAlarm, syncAlarm, trackSync, mode};
				ADDR_TIME: next_rdata = {15'h0000, todWord};
				ADDR_SYNC: next_rdata = {15'h0000, syncH, syncM, syncS};
				ADDR_SNAP_TIME: next_rdata = {15'h0000, snapTime};
				ADDR_SNAP_REMAIN: next_rdata = {15'h0000, snapRemain};
				ADDR_FIRST_ON: next_rdata = {15'h0000, firstOn};
				ADDR_VERSION: next_rdata = VERSION_ID;
				ADDR_POS_LAT: next_rdata = posLat;
				ADDR_POS_LON: next_rdata = posLon;
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode <= MODE_READ;
			inactCnt <= 10'h000;
			argReg <= 32'h00000000;
			arg2Reg <= 32'h00000000;
			respOp <= 4'h0;
			respResult <= RES_OK;
			respStateOn <= 1'b0;
			respSeq <= 8'h00;
			syncH <= SYNC_DEF_H;
			syncM <= SYNC_DEF_M;
			syncS <= SYNC_DEF_S;
			snapTime <= 17'h00000;
			snapRemain <= 17'h00000;
			firstOn <= 17'h00000;
			firstOnValid <= 1'b0;
			posLat <= 32'h00000000;
			posLon <= 32'h00000000;
			rcvResetPulse <= 1'b0;
			rstDoneSeen <= 1'b0;
			rdata <= 32'h00000000;
		end else begin
			mode <= next_mode;
			inactCnt <= next_inactCnt;
			argReg <= next_argReg;
			arg2Reg <= next_arg2Reg;
			respOp <= next_respOp;
			respResult <= next_respResult;
			respStateOn <= next_respStateOn;
			respSeq <= next_respSeq;
			syncH <= next_syncH;
			syncM <= next_syncM;
			syncS <= next_syncS;
			snapTime <= next_snapTime;
			snapRemain <= next_snapRemain;
			firstOn <= next_firstOn;
			firstOnValid <= next_firstOnValid;
			posLat <= next_posLat;
			posLon <= next_posLon;
			rcvResetPulse <= next_rcvResetPulse;
			rstDoneSeen <= next_rstDoneSeen;
			rdata <= next_rdata;
		end
	end

	// timer and alarm group
	always_comb begin
		next_secTick = 1'b0;
		next_secCnt = secCnt + 28'h0000001;
		if (secCnt == 28'(SEC_CYCLES_P - 1)) begin
			next_secCnt = 28'h0000000;
			next_secTick = 1'b1;
		end
		next_syncCnt = syncCnt;
		if (trackSync) begin
			next_syncCnt = 17'h00000;
		end else if (secTick && syncCnt < syncPeriodS) begin
			next_syncCnt = syncCnt + 17'h00001;
		end
		next_syncAlarm = !trackSync && (next_syncCnt >= syncPeriodS);
		next_rstBusy = rstBusy;
		next_rstCnt = rstCnt;
		next_rstDone = 1'b0;
		if (rcvResetPulse) begin
			next_rstBusy = 1'b1;
			next_rstCnt = 4'h0;
		end else if (rstBusy && secTick) begin
			// lands 9 to 10 seconds after the request, tick phase unknown
			if (rstCnt == RST_LAST) begin
				next_rstBusy = 1'b0;
				next_rstDone = 1'b1;
			end else begin
				next_rstCnt = rstCnt + 4'h1;
			end
		end
		next_majorAlarm = syncAlarm || (mode == MODE_TEST);
		next_minorAlarm = (mode == MODE_TEST);
		next_syncOutEnable = !syncAlarm;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			trackMeta <= 1'b0;
			trackSync <= 1'b0;
			secCnt <= 28'h0000000;
			secTick <= 1'b0;
			syncCnt <= 17'h00000;
			syncAlarm <= 1'b0;
			rstBusy <= 1'b0;
			rstCnt <= 4'h0;
			rstDone <= 1'b0;
			majorAlarm <= 1'b0;
			minorAlarm <= 1'b0;
			syncOutEnable <= 1'b1;
		end else begin
			trackMeta <= rcvTracking;
			trackSync <= trackMeta;
			secCnt <= next_secCnt;
			secTick <= next_secTick;
			syncCnt <= next_syncCnt;
			syncAlarm <= next_syncAlarm;
			rstBusy <= next_rstBusy;
			rstCnt <= next_rstCnt;
			rstDone <= next_rstDone;
			majorAlarm <= next_majorAlarm;
			minorAlarm <= next_minorAlarm;
			syncOutEnable <= next_syncOutEnable;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_param_refused;
		cmdWr && op == OP_POSITION && mode != MODE_SET |=> respResult == RES_REFUSED && $stable(posLat);
	endproperty
	a_param_refused: assert property (p_param_refused)
		else $error("position taken outside set mode");
	property p_set_lapse;
		mode == MODE_SET && secTick && inactCnt == INACT_LAST && !cmdWr |=> mode == MODE_READ;
	endproperty
	a_set_lapse: assert property (p_set_lapse)
		else $error("set mode did not lapse");
	property p_sm_on;
		cmdWr && op == OP_SET_MODE && hasArg && argOn |=> mode == MODE_SET && respStateOn;
	endproperty
	a_sm_on: assert property (p_sm_on)
		else $error("set mode on not entered or echoed");
	property p_sync_clear;
		trackSync |=> syncCnt == 17'h00000 ##1 !syncAlarm;
	endproperty
	a_sync_clear: assert property (p_sync_clear)
		else $error("sync timer not cleared");
	property p_sync_alarm;
		syncAlarm |=> majorAlarm && !syncOutEnable;
	endproperty
	a_sync_alarm: assert property (p_sync_alarm)
		else $error("sync alarm without major alarm");
	property p_sync_guard;
		cmdWr && op == OP_SYNC && hasArg && mode != MODE_SET |=> $stable(syncH) && $stable(syncM);
	endproperty
	a_sync_guard: assert property (p_sync_guard)
		else $error("sync period changed outside set mode");
	property p_tod_range;
		hours <= MAX_HOUR && minutes <= MAX_MIN && seconds <= MAX_SEC;
	endproperty
	a_tod_range: assert property (p_tod_range)
		else $error("time of day out of range");
	property p_rcv_overwrite;
		rcvTimeValid && trackSync |=> hours == $past(rcvHours) && seconds == $past(rcvSeconds);
	endproperty
	a_rcv_overwrite: assert property (p_rcv_overwrite)
		else $error("receiver time not loaded");
	property p_test_alarms;
		mode == MODE_TEST |=> majorAlarm && minorAlarm;
	endproperty
	a_test_alarms: assert property (p_test_alarms)
		else $error("test mode without both alarms");
	property p_reset_gate;
		cmdWr && op == OP_RCV_RESET && mode != MODE_TEST |=> !rcvResetPulse;
	endproperty
	a_reset_gate: assert property (p_reset_gate)
		else $error("receiver reset outside test mode");
	property p_inact_restart;
		cmdWr |=> inactCnt == 10'h000;
	endproperty
	a_inact_restart: assert property (p_inact_restart)
		else $error("command did not restart countdown");

	c_test_entry: cover property (mode == MODE_READ ##1 mode == MODE_TEST);
	c_sync_alarm: cover property ($rose(syncAlarm));
	c_reset_done: cover property (rstDone);
	c_manual_time: cover property (todLoad && !rcvTimeValid);
endmodule // gcs_setup_cmd

// File: test/gcs_rcv_model.sv
`timescale 1ns/10ps
module gcs_rcv_model #(
	parameter int TICK = 20
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       trackOn,
	output logic            rcvTracking,
	output logic            rcvTimeValid,
	output logic      [4:0] rcvHours,
	output logic      [5:0] rcvMinutes,
	output logic      [5:0] rcvSeconds
);
	int         div;
	logic [5:0] secs;

	// seconds wrap at 30 so the block's own tick never rolls the minute
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			div <= 0;
			secs <= 6'h00;
			rcvTracking <= 1'b0;
			rcvTimeValid <= 1'b0;
		end else begin
			rcvTracking <= trackOn;
			div <= (div == TICK - 1) ? 0 : div + 1;
			rcvTimeValid <= trackOn && (div == TICK - 1);
			if (div == TICK - 1) begin
				secs <= (secs == 6'h1d) ? 6'h00 : secs + 6'h01;
			end
		end
	end

	// between time words the fields show the inverse, never a stale copy
	assign rcvHours = rcvTimeValid ? 5'h0a : 5'h15;
	assign rcvMinutes = rcvTimeValid ? 6'h14 : 6'h2b;
	assign rcvSeconds = rcvTimeValid ? secs : ~secs;
endmodule // gcs_rcv_model

// File: test/tb_gcs_setup_cmd.sv
`timescale 1ns/10ps
module tb_gcs_setup_cmd;
	import gcs_pkg::*;
	localparam int SEC = 20;
	typedef struct {
		string       name;
		logic [31:0] exp;
		logic [31:0] mask;
	} gcs_note_t;

	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        trackOn = 1'b0;
	logic        rdSeen = 1'b0;
	logic [31:0] rdata;
	logic        rcvTracking;
	logic        rcvTimeValid;
	logic [4:0]  rcvHours;
	logic [5:0]  rcvMinutes;
	logic [5:0]  rcvSeconds;
	logic        majorAlarm;
	logic        minorAlarm;
	logic        syncOutEnable;
	logic        rcvResetPulse;
	logic [31:0] seed = 32'h0001601e;
	logic [3:0]  refuseOps [4] = '{OP_SYNC, OP_TIME, OP_POSITION, OP_RCV_RESET};
	int          n_mismatch = 0;
	int          checks = 0;
	int          nPulse = 0;
	gcs_note_t   notes [$];
	gcs_note_t   cur;

	gcs_setup_cmd #(.SEC_CYCLES_P(SEC)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rcvTracking(rcvTracking), .rcvTimeValid(rcvTimeValid),
		.rcvHours(rcvHours), .rcvMinutes(rcvMinutes), .rcvSeconds(rcvSeconds),
		.majorAlarm(majorAlarm), .minorAlarm(minorAlarm), .syncOutEnable(syncOutEnable),
		.rcvResetPulse(rcvResetPulse)
	);

	gcs_rcv_model #(.TICK(SEC)) rcv (
		.ref_clk(ref_clk), .rst_n(rst_n), .trackOn(trackOn), .rcvTracking(rcvTracking),
		.rcvTimeValid(rcvTimeValid), .rcvHours(rcvHours), .rcvMinutes(rcvMinutes),
		.rcvSeconds(rcvSeconds)
	);

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] gcs_lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] hms(input int h, input int m, input int s);
		return 32'((h << 12) | (m << 6) | s);
	endfunction

	task automatic tally_and_finish;
		if (n_mismatch == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic track(input logic v);
		@(posedge ref_clk);
		trackOn <= v;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input string nm, input logic [7:0] a, input logic [31:0] e,
			input logic [31:0] m);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		notes.push_back(gcs_note_t'{nm, e, m});
		@(posedge ref_clk);
		rd <= 1'b0;
	endtask

	task automatic cmd(input logic [3:0] op, input logic has, input logic on,
			input logic [1:0] res, input logic echo, input logic [31:0] m);
		wreg(ADDR_CMD, 32'({on, has, op}));
		rreg("resp", ADDR_RESP, 32'({echo, res, op}), m);
	endtask

	// alarms sampled mid-cycle, packed as major, minor, output enable
	task automatic flags(input logic [2:0] e);
		@(negedge ref_clk);
		chk("alarms", 32'(e), 32'({majorAlarm, minorAlarm, syncOutEnable}));
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge ref_clk) begin
		rdSeen <= rd;
		if (rcvResetPulse === 1'b1) begin
			nPulse++;
		end
	end

	always @(negedge ref_clk) begin
		if (rdSeen) begin
			cur = notes.pop_front();
			chk(cur.name, cur.exp & cur.mask, rdata & cur.mask);
		end
	end

	initial begin
		#(60000 * 5);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		int          h;
		int          m;
		logic [31:0] lat;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		flags(3'b001);
		rreg("status", ADDR_STATUS, 32'h0, 32'h1ff);
		rreg("sync", ADDR_SYNC, hms(2, 0, 0), '1);
		rreg("version", ADDR_VERSION, VERSION_ID, '1);
		rreg("cmd", ADDR_CMD, 32'h0, '1);
		rreg("unmapped", 8'h3c, 32'h0, '1);
		wreg(ADDR_ARG, hms(1, 2, 3));
		foreach (refuseOps[i]) begin
			cmd(refuseOps[i], 1'b1, 1'b0, RES_REFUSED, 1'b0, 32'h3f);
		end
		cmd(4'hf, 1'b0, 1'b0, RES_BAD_OP, 1'b0, 32'h3f);
		cmd(OP_SET_MODE, 1'b0, 1'b0, RES_OK, 1'b0, 32'h7f);
		cmd(OP_SET_MODE, 1'b1, 1'b1, RES_OK, 1'b1, 32'h7f);
		cmd(OP_SET_MODE, 1'b0, 1'b0, RES_OK, 1'b1, 32'h7f);
		rreg("mode", ADDR_STATUS, 32'h1, 32'h3);
		// short period, assumed above any lock period upstream
		wreg(ADDR_ARG, hms(0, 0, 5));
		cmd(OP_SYNC, 1'b1, 1'b0, RES_OK, 1'b0, 32'h3f);
		wreg(ADDR_ARG, hms(0, 60, 0));
		cmd(OP_SYNC, 1'b1, 1'b0, RES_REFUSED, 1'b0, 32'h3f);
		rreg("sync", ADDR_SYNC, hms(0, 0, 5), '1);
		wreg(ADDR_ARG, hms(24, 0, 0));
		cmd(OP_TIME, 1'b1, 1'b0, RES_REFUSED, 1'b0, 32'h3f);
		wreg(ADDR_ARG, hms(23, 59, 60));
		cmd(OP_TIME, 1'b1, 1'b0, RES_OK, 1'b0, 32'h3f);
		seed = gcs_lfsr(seed);
		h = int'(seed % 24);
		m = int'((seed >> 8) % 60);
		wreg(ADDR_ARG, hms(h, m, 30));
		cmd(OP_TIME, 1'b1, 1'b0, RES_OK, 1'b0, 32'h3f);
		rreg("time", ADDR_TIME, hms(h, m, 0), 32'h1ffc0);
		track(1'b1);
		cyc(10);
		flags(3'b001);
		track(1'b0);
		cyc(60);
		flags(3'b001);
		cyc(100);
		flags(3'b100);
		rreg("syncAlarm", ADDR_STATUS, 32'h18, 32'h18);
		track(1'b1);
		cyc(10);
		flags(3'b001);
		cyc(30);
		rreg("rcvTime", ADDR_TIME, hms(10, 20, 0), 32'h1ffc0);
		wreg(ADDR_ARG, hms(5, 0, 0));
		wreg(ADDR_CMD, 32'({1'b0, 1'b1, OP_TIME}));
		cyc(30);
		rreg("rcvTime", ADDR_TIME, hms(10, 20, 0), 32'h1ffc0);
		rreg("firstOn", ADDR_FIRST_ON, hms(10, 20, 0), 32'h1ffc0);
		cmd(OP_STATUS, 1'b0, 1'b0, RES_OK, 1'b0, 32'h3f);
		rreg("remain", ADDR_SNAP_REMAIN, 32'h5, '1);
		rreg("snapTime", ADDR_SNAP_TIME, hms(10, 20, 0), 32'h1ffc0);
		cmd(OP_VERSION, 1'b0, 1'b0, RES_OK, 1'b1, 32'h7f);
		seed = gcs_lfsr(seed);
		lat = seed;
		seed = gcs_lfsr(seed);
		wreg(ADDR_ARG, lat);
		wreg(ADDR_ARG2, seed);
		cmd(OP_POSITION, 1'b1, 1'b0, RES_OK, 1'b0, 32'h3f);
		rreg("lat", ADDR_POS_LAT, lat, '1);
		rreg("lon", ADDR_POS_LON, seed, '1);
		cmd(OP_RCV_RESET, 1'b0, 1'b0, RES_REFUSED, 1'b0, 32'h3f);
		cmd(OP_TEST_MODE, 1'b1, 1'b1, RES_OK, 1'b1, 32'h7f);
		flags(3'b111);
		rreg("snapTime", ADDR_SNAP_TIME, hms(10, 20, 0), 32'h1ffc0);
		cmd(OP_TEST_MODE, 1'b0, 1'b0, RES_OK, 1'b1, 32'h7f);
		rreg("mode", ADDR_STATUS, 32'h2, 32'h3);
		chk("pulses", 32'h0, 32'(nPulse));
		cmd(OP_RCV_RESET, 1'b0, 1'b0, RES_OK, 1'b0, 32'h3f);
		chk("pulses", 32'h1, 32'(nPulse));
		cyc(150);
		rreg("resetDone", ADDR_RESP, 32'h0, 32'h30);
		rreg("resetBusy", ADDR_STATUS, 32'h40, 32'h140);
		cyc(80);
		rreg("resetDone", ADDR_RESP, 32'h30, 32'h30);
		rreg("resetSeen", ADDR_STATUS, 32'h100, 32'h140);
		cyc(12000);
		cmd(OP_TEST_MODE, 1'b0, 1'b0, RES_OK, 1'b1, 32'h7f);
		cyc(12000);
		rreg("mode", ADDR_STATUS, 32'h2, 32'h3);
		cyc(6500);
		rreg("mode", ADDR_STATUS, 32'h0, 32'h3);
		flags(3'b001);
		cmd(OP_SET_MODE, 1'b1, 1'b1, RES_OK, 1'b1, 32'h7f);
		cyc(17700);
		rreg("mode", ADDR_STATUS, 32'h1, 32'h3);
		cyc(500);
		rreg("mode", ADDR_STATUS, 32'h0, 32'h3);
		cmd(OP_SET_MODE, 1'b1, 1'b1, RES_OK, 1'b1, 32'h7f);
		cmd(OP_SET_MODE, 1'b1, 1'b0, RES_OK, 1'b0, 32'h7f);
		rreg("mode", ADDR_STATUS, 32'h0, 32'h3);
		cmd(OP_TEST_MODE, 1'b1, 1'b1, RES_OK, 1'b1, 32'h7f);
		cmd(OP_TEST_MODE, 1'b1, 1'b0, RES_OK, 1'b0, 32'h7f);
		rreg("mode", ADDR_STATUS, 32'h0, 32'h3);
		flags(3'b001);
		cyc(2);
		tally_and_finish();
	end
endmodule // tb_gcs_setup_cmd
